// ==== rtl/eth_stats_defines.svh ====
// Offsets, field positions, reset values and length limits of the statistics block
`ifndef ETH_STATS_DEFINES_SVH
`define ETH_STATS_DEFINES_SVH
// Counter indices; byte address is index times four
`define IDX_DEFER 4'h0
`define IDX_COLL 4'h1
`define IDX_SINGLE 4'h2
`define IDX_MULTI 4'h3
`define IDX_EXCESS 4'h4
`define IDX_LATE 4'h5
`define IDX_STARVE 4'h6
`define IDX_CARRIER 4'h7
`define IDX_TXBYTES 4'h8
`define IDX_BIN64 4'h9
`define IDX_BIN65 4'ha
`define IDX_BIN128 4'hb
`define IDX_BIN256 4'hc
`define IDX_BIN512 4'hd
`define IDX_BIN1024 4'he
`define IDX_NETBYTES 4'hf
// Byte offsets of the register window
`define OFS_CNT_LAST 8'h3c
`define OFS_CTRL 8'h40
// Control register fields and reset value
`define CTRL_HALF_DUPLEX 0
`define CTRL_FLOW_CTRL 1
`define CTRL_RESET 2'h0
// Collision count limits
`define COLL_ONE 5'h01
`define COLL_MULTI_MIN 5'h02
`define COLL_MULTI_MAX 5'h0f
`define COLL_ABANDON 5'h10
// Frame length bin limits in bytes
`define LEN_64 16'h0040
`define LEN_127 16'h007f
`define LEN_255 16'h00ff
`define LEN_511 16'h01ff
`define LEN_1023 16'h03ff
`define LEN_1518 16'h05ee
`endif

// ==== rtl/eth_stats_pkg.sv ====
// Types shared by the statistics block and its neighbours
package eth_stats_pkg;
	// One collision seen by the transmit engine
	typedef struct packed {
		logic valid;
		logic late;
		logic [15:0] bytes;
	} tx_coll_t;
	// Final outcome of one transmitted frame
	typedef struct packed {
		logic valid;
		logic deferred;
		logic [4:0] coll_count;
		logic late_coll;
		logic underrun;
		logic carrier_loss;
		logic [15:0] bytes;
	} tx_done_t;
	// End of one received frame
	typedef struct packed {
		logic valid;
		logic jammed;
		logic [15:0] bytes;
	} rx_done_t;
	// Whole state of the statistics block
	typedef struct packed {
		logic [15:0][31:0] cnt;
		logic [1:0] ctrl;
		logic ack;
		logic [31:0] rdata;
	} stats_state_t;
endpackage : eth_stats_pkg

// ==== rtl/eth_tx_and_size_statistics.sv ====
// Transmit, length-bin and network utilisation statistics with Avalon-MM access
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "eth_stats_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module eth_tx_and_size_statistics
	import eth_stats_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire tx_coll_t i_tx_coll,
	input wire tx_done_t i_tx_done,
	input wire rx_done_t i_rx_done,
	input wire logic i_rx_start,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_half_duplex,
	output logic o_flow_ctrl
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	stats_state_t state_reg; // Registered state
	stats_state_t state_next; // Next state
	logic [15:0][31:0] inc; // Per-counter increment this cycle
	logic [15:0] clr; // Per-counter clear by software write
	logic bus_req; // Read or write pending
	logic wr_take; // Write completes this edge
	logic tx_exc; // Frame abandoned after 16 collisions
	logic tx_clean; // No carrier loss and no underrun
	logic tx_good; // Good transmitted frame
	logic tx_binq; // Transmit frame qualifies for a bin
	logic rx_binq; // Receive frame qualifies for a bin
	logic fc_coll; // Flow-control collision on reception start
	logic [5:0] tx_bins; // One-hot transmit bin
	logic [5:0] rx_bins; // One-hot receive bin

	////////////////////////////////////////////////////////////////////////////
	// Length classification
	function automatic logic [5:0] bin_of(input logic [15:0] len);
		logic [5:0] b;
		b = 6'h00;
		if (len == `LEN_64) begin
			b[0] = 1'b1;
		end else if (len <= `LEN_127 && len > `LEN_64) begin
			b[1] = 1'b1;
		end else if (len <= `LEN_255 && len > `LEN_127) begin
			b[2] = 1'b1;
		end else if (len <= `LEN_511 && len > `LEN_255) begin
			b[3] = 1'b1;
		end else if (len <= `LEN_1023 && len > `LEN_511) begin
			b[4] = 1'b1;
		end else if (len <= `LEN_1518 && len > `LEN_1023) begin
			b[5] = 1'b1;
		end
		return b;
	endfunction : bin_of

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign bus_req = i_avs_read | i_avs_write;
	// One wait cycle on every access
	assign o_avs_waitrequest = bus_req & ~state_reg.ack;
	assign o_avs_readdata = state_reg.rdata;
	assign o_half_duplex = state_reg.ctrl[`CTRL_HALF_DUPLEX];
	assign o_flow_ctrl = state_reg.ctrl[`CTRL_FLOW_CTRL];
	assign wr_take = i_avs_write & state_reg.ack;

	////////////////////////////////////////////////////////////////////////////
	// Frame qualification
	always_comb begin
		// Abandon needs 16 collisions with none late
		tx_exc = i_tx_done.valid & ~i_tx_done.late_coll
			& (i_tx_done.coll_count == `COLL_ABANDON);
		tx_clean = ~i_tx_done.carrier_loss & ~i_tx_done.underrun;
		tx_good = i_tx_done.valid & ~i_tx_done.late_coll & ~tx_exc & tx_clean;
		// Carrier-truncated frames binned only at 64 bytes
		tx_binq = i_tx_done.valid & ~i_tx_done.late_coll & ~tx_exc
			& ~i_tx_done.underrun
			& (~i_tx_done.carrier_loss | (i_tx_done.bytes == `LEN_64));
		// Receive error flags are not even inputs here
		rx_binq = i_rx_done.valid & ~i_rx_done.jammed;
		fc_coll = i_rx_start & state_reg.ctrl[`CTRL_HALF_DUPLEX]
			& state_reg.ctrl[`CTRL_FLOW_CTRL];
		tx_bins = tx_binq ? bin_of(i_tx_done.bytes) : 6'h00;
		rx_bins = rx_binq ? bin_of(i_rx_done.bytes) : 6'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter increments
	always_comb begin
		inc = '0;
		// Deferred then sent with no collision at all
		inc[`IDX_DEFER] = {31'h0, i_tx_done.valid & i_tx_done.deferred
			& (i_tx_done.coll_count == 5'h00) & ~i_tx_done.late_coll
			& tx_clean};
		// Each collision event and each flow-control collision
		inc[`IDX_COLL] = {31'h0, i_tx_coll.valid}
			+ {31'h0, fc_coll};
		// Late collision keeps the frame out of these three
		inc[`IDX_SINGLE] = {31'h0, i_tx_done.valid & ~i_tx_done.late_coll
			& (i_tx_done.coll_count == `COLL_ONE) & tx_clean};
		inc[`IDX_MULTI] = {31'h0, i_tx_done.valid & ~i_tx_done.late_coll
			& (i_tx_done.coll_count >= `COLL_MULTI_MIN)
			& (i_tx_done.coll_count <= `COLL_MULTI_MAX)
			& tx_clean};
		inc[`IDX_EXCESS] = {31'h0, tx_exc & tx_clean};
		// Late frames counted whatever else went wrong
		inc[`IDX_LATE] = {31'h0, i_tx_done.valid
			& i_tx_done.late_coll};
		inc[`IDX_STARVE] = {31'h0, i_tx_done.valid
			& i_tx_done.underrun};
		inc[`IDX_CARRIER] = {31'h0, i_tx_done.valid
			& i_tx_done.carrier_loss};
		inc[`IDX_TXBYTES] = tx_good ? {16'h0, i_tx_done.bytes} : 32'h0;
		// Transmit and receive in one bin both land
		inc[`IDX_BIN64] = {31'h0, tx_bins[0]} + {31'h0, rx_bins[0]};
		inc[`IDX_BIN65] = {31'h0, tx_bins[1]} + {31'h0, rx_bins[1]};
		inc[`IDX_BIN128] = {31'h0, tx_bins[2]} + {31'h0, rx_bins[2]};
		inc[`IDX_BIN256] = {31'h0, tx_bins[3]} + {31'h0, rx_bins[3]};
		inc[`IDX_BIN512] = {31'h0, tx_bins[4]} + {31'h0, rx_bins[4]};
		inc[`IDX_BIN1024] = {31'h0, tx_bins[5]} + {31'h0, rx_bins[5]};
		// Aborted final attempts arrive through their collision event
		inc[`IDX_NETBYTES] = (i_tx_coll.valid ? {16'h0, i_tx_coll.bytes} : 32'h0)
			+ ((i_tx_done.valid & ~i_tx_done.late_coll & ~tx_exc)
			? {16'h0, i_tx_done.bytes} : 32'h0)
			+ (i_rx_done.valid ? {16'h0, i_rx_done.bytes} : 32'h0);
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state: bus slave and counters
	always_comb begin
		state_next = state_reg;
		clr = 16'h0000;
		// Acknowledge one cycle after the request appears
		state_next.ack = bus_req & ~state_reg.ack;
		// Read data captured in the wait cycle
		if (i_avs_read & ~state_reg.ack) begin
			if (i_avs_address <= `OFS_CNT_LAST && i_avs_address[1:0] == 2'h0) begin
				state_next.rdata = state_reg.cnt[i_avs_address[5:2]];
			end else if (i_avs_address == `OFS_CTRL) begin
				state_next.rdata = {30'h0, state_reg.ctrl};
			end else begin
				state_next.rdata = 32'h0; // Unmapped reads zero
			end
		end
		// Writes land one edge after the wait ends, at the edge where waitrequest is low
		if (wr_take) begin
			if (i_avs_address <= `OFS_CNT_LAST && i_avs_address[1:0] == 2'h0) begin
				clr[i_avs_address[5:2]] = 1'b1;
			end else if (i_avs_address == `OFS_CTRL) begin
				state_next.ctrl = i_avs_writedata[1:0];
			end
		end
		// Clearing write loses nothing arriving the same cycle
		for (int i = 0; i < 16; i++) begin
			state_next.cnt[i] = (clr[i] ? 32'h0 : state_reg.cnt[i]) + inc[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_reg.cnt <= '0;
			state_reg.ctrl <= `CTRL_RESET;
			state_reg.ack <= 1'b0;
			state_reg.rdata <= 32'h0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// Transmit outcome of the current cycle
	sequence s_done_clean;
		i_tx_done.valid && !i_tx_done.carrier_loss && !i_tx_done.underrun
			&& !i_tx_done.late_coll;
	endsequence

	property p_deferred;
		s_done_clean and (i_tx_done.deferred && i_tx_done.coll_count == 5'h00
			&& !clr[`IDX_DEFER])
		|=> state_reg.cnt[`IDX_DEFER] == $past(state_reg.cnt[`IDX_DEFER]) + 32'h1;
	endproperty
	a_deferred: assert property (p_deferred) else $error("deferred count missed");

	property p_coll_both;
		i_tx_coll.valid && fc_coll && !clr[`IDX_COLL]
		|=> state_reg.cnt[`IDX_COLL] == $past(state_reg.cnt[`IDX_COLL]) + 32'h2;
	endproperty
	a_coll_both: assert property (p_coll_both) else $error("collision sum wrong");

	property p_fc_coll;
		i_rx_start && o_half_duplex && o_flow_ctrl && !i_tx_coll.valid
			&& !clr[`IDX_COLL]
		|=> state_reg.cnt[`IDX_COLL] == $past(state_reg.cnt[`IDX_COLL]) + 32'h1;
	endproperty
	a_fc_coll: assert property (p_fc_coll) else $error("flow collision missed");

	property p_single;
		s_done_clean and (i_tx_done.coll_count == 5'h01 && !clr[`IDX_SINGLE]
			&& !clr[`IDX_MULTI])
		|=> state_reg.cnt[`IDX_SINGLE] == $past(state_reg.cnt[`IDX_SINGLE]) + 32'h1
			&& state_reg.cnt[`IDX_MULTI] == $past(state_reg.cnt[`IDX_MULTI]);
	endproperty
	a_single: assert property (p_single) else $error("single count wrong");

	property p_multi;
		s_done_clean and (i_tx_done.coll_count == 5'h0f && !clr[`IDX_MULTI])
		|=> state_reg.cnt[`IDX_MULTI] == $past(state_reg.cnt[`IDX_MULTI]) + 32'h1;
	endproperty
	a_multi: assert property (p_multi) else $error("multiple count wrong");

	property p_excess;
		s_done_clean and (i_tx_done.coll_count == 5'h10 && !clr[`IDX_EXCESS]
			&& !clr[`IDX_MULTI])
		|=> state_reg.cnt[`IDX_EXCESS] == $past(state_reg.cnt[`IDX_EXCESS]) + 32'h1
			&& state_reg.cnt[`IDX_MULTI] == $past(state_reg.cnt[`IDX_MULTI]);
	endproperty
	a_excess: assert property (p_excess) else $error("excessive count wrong");

	property p_late;
		i_tx_done.valid && i_tx_done.late_coll && !clr[`IDX_LATE]
			&& !clr[`IDX_SINGLE]
		|=> state_reg.cnt[`IDX_LATE] == $past(state_reg.cnt[`IDX_LATE]) + 32'h1
			&& state_reg.cnt[`IDX_SINGLE] == $past(state_reg.cnt[`IDX_SINGLE]);
	endproperty
	a_late: assert property (p_late) else $error("late count wrong");

	property p_bin64_carrier;
		i_tx_done.valid && i_tx_done.carrier_loss && !i_tx_done.late_coll
			&& !i_tx_done.underrun && i_tx_done.bytes == 16'h0040
			&& i_tx_done.coll_count == 5'h00 && !i_rx_done.valid
			&& !clr[`IDX_BIN64]
		|=> state_reg.cnt[`IDX_BIN64] == $past(state_reg.cnt[`IDX_BIN64]) + 32'h1;
	endproperty
	a_bin64_carrier: assert property (p_bin64_carrier) else $error("bin64 missed");

	property p_rx_net;
		i_rx_done.valid && !i_tx_done.valid && !i_tx_coll.valid
			&& !clr[`IDX_NETBYTES]
		|=> state_reg.cnt[`IDX_NETBYTES] == $past(state_reg.cnt[`IDX_NETBYTES])
			+ {16'h0, $past(i_rx_done.bytes)};
	endproperty
	a_rx_net: assert property (p_rx_net) else $error("net bytes wrong");

	// Underrun counted whatever else went wrong
	property p_starve;
		i_tx_done.valid && i_tx_done.underrun && !clr[`IDX_STARVE]
		|=> state_reg.cnt[`IDX_STARVE] == $past(state_reg.cnt[`IDX_STARVE]) + 32'h1;
	endproperty
	a_starve: assert property (p_starve) else $error("underrun count missed");

	// Carrier loss counted and kept out of the good byte total
	property p_carrier;
		i_tx_done.valid && i_tx_done.carrier_loss && !clr[`IDX_CARRIER]
			&& !clr[`IDX_TXBYTES]
		|=> state_reg.cnt[`IDX_CARRIER] == $past(state_reg.cnt[`IDX_CARRIER]) + 32'h1
			&& state_reg.cnt[`IDX_TXBYTES] == $past(state_reg.cnt[`IDX_TXBYTES]);
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier count wrong");

	// Good frame adds its whole length
	property p_tx_bytes;
		s_done_clean and (i_tx_done.coll_count != `COLL_ABANDON && !clr[`IDX_TXBYTES])
		|=> state_reg.cnt[`IDX_TXBYTES] == $past(state_reg.cnt[`IDX_TXBYTES])
			+ {16'h0, $past(i_tx_done.bytes)};
	endproperty
	a_tx_bytes: assert property (p_tx_bytes) else $error("good bytes wrong");

	// Receive frame alone in its cycle and eligible for a bin
	sequence s_rx_binned;
		i_rx_done.valid && !i_rx_done.jammed && !i_tx_done.valid;
	endsequence

	property p_bin_small;
		s_rx_binned and (i_rx_done.bytes > `LEN_64 && i_rx_done.bytes <= `LEN_127
			&& !clr[`IDX_BIN65])
		|=> state_reg.cnt[`IDX_BIN65] == $past(state_reg.cnt[`IDX_BIN65]) + 32'h1;
	endproperty
	a_bin_small: assert property (p_bin_small) else $error("bin small missed");

	property p_bin_medium_small;
		s_rx_binned and (i_rx_done.bytes > `LEN_127 && i_rx_done.bytes <= `LEN_255
			&& !clr[`IDX_BIN128])
		|=> state_reg.cnt[`IDX_BIN128] == $past(state_reg.cnt[`IDX_BIN128]) + 32'h1;
	endproperty
	a_bin_medium_small: assert property (p_bin_medium_small) else $error("bin 128 missed");

	property p_bin_medium;
		s_rx_binned and (i_rx_done.bytes > `LEN_255 && i_rx_done.bytes <= `LEN_511
			&& !clr[`IDX_BIN256])
		|=> state_reg.cnt[`IDX_BIN256] == $past(state_reg.cnt[`IDX_BIN256]) + 32'h1;
	endproperty
	a_bin_medium: assert property (p_bin_medium) else $error("bin medium missed");

	property p_bin_large;
		s_rx_binned and (i_rx_done.bytes > `LEN_511 && i_rx_done.bytes <= `LEN_1023
			&& !clr[`IDX_BIN512])
		|=> state_reg.cnt[`IDX_BIN512] == $past(state_reg.cnt[`IDX_BIN512]) + 32'h1;
	endproperty
	a_bin_large: assert property (p_bin_large) else $error("bin large missed");

	property p_bin_max;
		s_rx_binned and (i_rx_done.bytes > `LEN_1023 && i_rx_done.bytes <= `LEN_1518
			&& !clr[`IDX_BIN1024])
		|=> state_reg.cnt[`IDX_BIN1024] == $past(state_reg.cnt[`IDX_BIN1024]) + 32'h1;
	endproperty
	a_bin_max: assert property (p_bin_max) else $error("bin max missed");

	// Underrun never stops network byte accumulation
	property p_net_starve;
		i_tx_done.valid && i_tx_done.underrun && !i_tx_done.late_coll
			&& i_tx_done.coll_count != `COLL_ABANDON && !i_tx_coll.valid
			&& !i_rx_done.valid && !clr[`IDX_NETBYTES]
		|=> state_reg.cnt[`IDX_NETBYTES] == $past(state_reg.cnt[`IDX_NETBYTES])
			+ {16'h0, $past(i_tx_done.bytes)};
	endproperty
	a_net_starve: assert property (p_net_starve) else $error("net bytes lost");

	// Late frame adds only the bytes sent before its collision
	property p_net_late;
		i_tx_coll.valid && i_tx_done.valid && i_tx_done.late_coll
			&& !i_rx_done.valid && !clr[`IDX_NETBYTES]
		|=> state_reg.cnt[`IDX_NETBYTES] == $past(state_reg.cnt[`IDX_NETBYTES])
			+ {16'h0, $past(i_tx_coll.bytes)};
	endproperty
	a_net_late: assert property (p_net_late) else $error("late net bytes wrong");

	// Control write reaches the mode pins
	property p_ctrl_write;
		wr_take && i_avs_address == `OFS_CTRL
		|=> {o_flow_ctrl, o_half_duplex} == $past(i_avs_writedata[1:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	// Clearing write with no event leaves zero
	property p_clear_idle;
		wr_take && i_avs_address == `OFS_CNT_LAST && !i_tx_done.valid
			&& !i_tx_coll.valid && !i_rx_done.valid
		|=> state_reg.cnt[`IDX_NETBYTES] == 32'h0;
	endproperty
	a_clear_idle: assert property (p_clear_idle) else $error("counter not cleared");

	// Read data only moves when a read is captured
	property p_rdata_stands;
		!(i_avs_read && !state_reg.ack) |=> $stable(o_avs_readdata);
	endproperty
	a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");

	// Request waits exactly one cycle then completes
	sequence s_bus_wait;
		bus_req && !state_reg.ack ##0 o_avs_waitrequest;
	endsequence
	property p_bus_answer;
		s_bus_wait |=> !o_avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("no bus answer");

endmodule : eth_tx_and_size_statistics

// ==== testbench/eth_mac_event_model.sv ====
// Behavioural model of the transmit and receive engines raising statistics events
`timescale 1ns/1ns
module eth_mac_event_model
	import eth_stats_pkg::*;
(
	input wire logic i_clock,
	output tx_coll_t o_tx_coll,
	output tx_done_t o_tx_done,
	output rx_done_t o_rx_done,
	output logic o_rx_start
);
	// Idle at time zero
	initial begin
		o_tx_coll = '0;
		o_tx_done = '0;
		o_rx_done = '0;
		o_rx_start = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One-cycle pulse of any mix of events; released fields carry inverted junk
	task automatic send(input tx_done_t t, input rx_done_t r, input tx_coll_t c, input logic s);
		@(posedge i_clock);
		o_tx_done <= t;
		o_rx_done <= r;
		o_tx_coll <= c;
		o_rx_start <= s;
		@(posedge i_clock);
		o_tx_done <= tx_done_t'({1'b0, ~t[24:0]});
		o_rx_done <= rx_done_t'({1'b0, ~r[16:0]});
		o_tx_coll <= tx_coll_t'({1'b0, ~c[16:0]});
		o_rx_start <= 1'b0;
	endtask : send
endmodule : eth_mac_event_model

// ==== testbench/tb_eth_tx_and_size_statistics.sv ====
// Self-checking bench for the transmit and frame length statistics block
`timescale 1ns/1ns
module tb_eth_tx_and_size_statistics
	import eth_stats_pkg::*;
;
	logic i_clock, i_rst, i_avs_read, i_avs_write, o_avs_waitrequest, o_half_duplex, o_flow_ctrl;
	logic [7:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata, rd;
	tx_coll_t tx_coll;
	tx_done_t tx_done;
	rx_done_t rx_done;
	logic rx_start;
	logic [31:0] exp_cnt [16]; // Expected counters
	logic [1:0] ctrl_exp; // Expected control bits
	int failures, samples_checked;
	// Transmit frames: flags {deferred, late, underrun, carrier}, collisions, bytes
	logic [24:0] tx_tab [13] = '{{4'h8, 5'h00, 16'h0040}, {4'h8, 5'h01, 16'h0041},
		{4'h0, 5'h02, 16'h0080}, {4'h0, 5'h0f, 16'h00ff}, {4'h0, 5'h10, 16'h0100},
		{4'h6, 5'h03, 16'h012c}, {4'h2, 5'h00, 16'h01ff}, {4'h1, 5'h00, 16'h0040},
		{4'h1, 5'h00, 16'h0046}, {4'h1, 5'h10, 16'h0400}, {4'h0, 5'h00, 16'h05ee},
		{4'ha, 5'h00, 16'h0040}, {4'h0, 5'h01, 16'h0200}};
	// Received lengths around the bin edges
	logic [15:0] rx_tab [8] = '{16'h03ff, 16'h0400, 16'h05ef, 16'h003f, 16'h007f, 16'h0100,
		16'h0041, 16'h0080};

	eth_tx_and_size_statistics dut (.i_clock(i_clock), .i_rst(i_rst), .i_tx_coll(tx_coll),
		.i_tx_done(tx_done), .i_rx_done(rx_done), .i_rx_start(rx_start),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .o_half_duplex(o_half_duplex),
		.o_flow_ctrl(o_flow_ctrl));
	eth_mac_event_model partner (.i_clock(i_clock), .o_tx_coll(tx_coll), .o_tx_done(tx_done),
		.o_rx_done(rx_done), .o_rx_start(rx_start));

	// 100 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare one word
	task automatic check(input string name, input logic [31:0] want, input logic [31:0] got);
		samples_checked++;
		if (got !== want) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, want, got);
		end
	endtask : check

	// Avalon-MM cycle held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic w;
		@(posedge i_clock);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_read <= ~wr;
		i_avs_write <= wr;
		do begin
			@(posedge i_clock);
			w = o_avs_waitrequest;
			rd = o_avs_readdata;
		end while (w !== 1'b0);
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask : bus

	// Read and compare one register
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] want);
		bus(1'b0, a, 32'h0);
		check(name, want, rd);
	endtask : rd_chk

	// Read back all sixteen counters
	task automatic check_all();
		for (int i = 0; i < 16; i++) begin
			rd_chk($sformatf("counter %0d", i), 8'(i * 4), exp_cnt[i]);
		end
	endtask : check_all

	// Bin index of a length, zero when no bin takes it
	function automatic int bin_idx(input logic [15:0] n);
		if (n == 16'h0040) return 9;
		if (n < 16'h0041 || n > 16'h05ee) return 0;
		return n <= 16'h007f ? 10 : n <= 16'h00ff ? 11 : n <= 16'h01ff ? 12 : n <= 16'h03ff ? 13 : 14;
	endfunction : bin_idx

	// Fire events and advance the expected counters
	task automatic send(input tx_done_t t, input rx_done_t r, input tx_coll_t c, input logic s);
		logic clean, ok;
		clean = t.valid && !t.late_coll && !t.underrun && !t.carrier_loss;
		ok = t.valid && !t.late_coll && t.coll_count != 5'h10;
		partner.send(t, r, c, s);
		exp_cnt[1] += 32'(c.valid) + 32'(s && ctrl_exp == 2'h3);
		if (c.valid) exp_cnt[15] += 32'(c.bytes);
		exp_cnt[0] += 32'(clean && t.deferred && t.coll_count == 5'h00);
		exp_cnt[2] += 32'(clean && t.coll_count == 5'h01);
		exp_cnt[3] += 32'(clean && t.coll_count inside {[5'h02:5'h0f]});
		exp_cnt[4] += 32'(clean && t.coll_count == 5'h10);
		exp_cnt[5] += 32'(t.valid && t.late_coll);
		exp_cnt[6] += 32'(t.valid && t.underrun);
		exp_cnt[7] += 32'(t.valid && t.carrier_loss);
		if (clean && ok) exp_cnt[8] += 32'(t.bytes);
		if (ok) exp_cnt[15] += 32'(t.bytes);
		if (ok && !t.underrun && (!t.carrier_loss || t.bytes == 16'h0040) && bin_idx(t.bytes) != 0)
			exp_cnt[bin_idx(t.bytes)]++;
		if (r.valid) exp_cnt[15] += 32'(r.bytes);
		if (r.valid && !r.jammed && bin_idx(r.bytes) != 0) exp_cnt[bin_idx(r.bytes)]++;
	endtask : send

	// Verdict and end of run
	task automatic print_verdict();
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog far beyond the few hundred cycles of the tests
	initial begin
		repeat (20000) @(posedge i_clock);
		failures++;
		print_verdict();
	end

	// Main sequence
	initial begin
		i_rst = 1'b1;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_address = 8'h00;
		i_avs_writedata = 32'h0;
		foreach (exp_cnt[i]) exp_cnt[i] = 32'h0;
		ctrl_exp = 2'h0;
		failures = 0;
		samples_checked = 0;
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		check_all();
		rd_chk("unmapped", 8'h44, 32'h0);
		rd_chk("misaligned", 8'h06, 32'h0);
		bus(1'b1, 8'h80, 32'hffffffff);
		bus(1'b1, 8'h40, 32'h1);
		ctrl_exp = 2'h1;
		send('0, '0, '0, 1'b1);
		bus(1'b1, 8'h40, 32'h3);
		ctrl_exp = 2'h3;
		rd_chk("control", 8'h40, 32'h3);
		check("mode pins", 32'h3, {30'h0, o_flow_ctrl, o_half_duplex});
		send('0, '{1'b1, 1'b1, 16'h005a}, '0, 1'b1);
		foreach (tx_tab[i])
			send({1'b1, tx_tab[i][24], tx_tab[i][20:16], tx_tab[i][23:21], tx_tab[i][15:0]}, '0,
				'{tx_tab[i][20:16] != 5'h00 || tx_tab[i][23], tx_tab[i][23], 16'h0020}, 1'b0);
		foreach (rx_tab[i]) send('0, '{1'b1, 1'b0, rx_tab[i]}, '0, 1'b0);
		send({7'h40, 3'h0, 16'h0040}, '{1'b1, 1'b0, 16'h0040}, '{1'b1, 1'b1, 16'h0010}, 1'b1);
		check_all();
		bus(1'b1, 8'h3c, 32'h0);
		bus(1'b1, 8'h24, 32'h0);
		exp_cnt[15] = 32'h0;
		exp_cnt[9] = 32'h0;
		check_all();
		// Reset in mid-run clears counters and control
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		foreach (exp_cnt[i]) exp_cnt[i] = 32'h0;
		ctrl_exp = 2'h0;
		rd_chk("control after reset", 8'h40, 32'h0);
		check("mode pins after reset", 32'h0, {30'h0, o_flow_ctrl, o_half_duplex});
		check_all();
		print_verdict();
	end
endmodule : tb_eth_tx_and_size_statistics
